// file: hw/pfm_pkg.sv
package pfm_pkg;
   // port 1 bit positions
   localparam int P1_AIN_POS = 0;
   localparam int P1_AIN_NEG = 1;
   localparam int P1_RST_DCL = 3;
   localparam int P1_SS = 4;
   localparam int P1_MOSI = 5;
   localparam int P1_MISO = 6;
   localparam int P1_SCK = 7;
   // port 3 bit positions
   localparam int P3_RXD = 0;
   localparam int P3_TXD = 1;
   localparam int P3_OSC_IN = 2;
   localparam int P3_OSC_OUT = 3;
   localparam int P3_T0 = 4;
   localparam int P3_T1 = 5;
   localparam int PORT_W = 8;
   // half clock divider: toggles every this many cycles
   localparam logic [0:0] HALF_CLK_RST = 1'h0;
   localparam logic [0:0] HALF_CLK_DIV = 1'h1;

   typedef struct packed {
      logic [7:0] in;
      logic [7:0] out;
      logic [7:0] oe;
   } pfm_pins_s;

   typedef struct packed {
      logic spi_master;
      logic rc_osc_sel;
      logic half_clk_en;
      logic onchip_debug;
      logic reset_fuse;
      logic uart_present;
      logic t0_pwm_en;
      logic t1_pwm_en;
   } pfm_cfg_s;
endpackage

// file: hw/pfm_pin_function_mux.sv
`timescale 1ns/10ps
// Behaviour
// - master drives mosi and sck, slave inputs
// - master inputs miso, slave drives it
// - port1 bit4 feeds spi slave select
// - rc oscillator frees oscillator pins for port
// - rc oscillator allows half clock output
// - debug with rc clock: data on p3.2
// - debug with external clock: data on p3.3
// - debug clock input taken on p1.3
// - reset fuse makes p1.3 active-low reset
// - every port1 bit feeds its irq input
// - p1.0/p1.1 feed comparator inputs
// - p3.5 is timer1 count or pwm
// - uart rx on p3.0, tx on p3.1
// - p3.4 is timer0 count or pwm
module pfm_pin_function_mux
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // configuration
   input wire pfm_pkg::pfm_cfg_s cfg,
   // port registers (out value, drive enable from port mode)
   input wire logic [7:0] port1_reg,
   input wire logic [7:0] port1_drv,
   input wire logic [7:0] port3_reg,
   input wire logic [7:0] port3_drv,
   // pins
   input wire logic [7:0] port1_pin_in,
   output logic [7:0] port1_pin_out,
   output logic [7:0] port1_pin_oe,
   input wire logic [7:0] port3_pin_in,
   output logic [7:0] port3_pin_out,
   output logic [7:0] port3_pin_oe,
   // port read-back
   output logic [7:0] port1_read,
   output logic [7:0] port3_read,
   // spi
   input wire logic spi_mosi_out,
   input wire logic spi_sck_out,
   input wire logic spi_miso_out,
   output logic spi_mosi_in,
   output logic spi_sck_in,
   output logic spi_miso_in,
   output logic spi_ss_n_in,
   // debug
   input wire logic debug_data_out,
   input wire logic debug_data_oe,
   output logic debug_data_line,
   output logic debug_clock_line,
   // reset, irq, comparator
   output logic ext_reset_n,
   output logic [7:0] gp_irq_in,
   output logic comparator_pos_in,
   output logic comparator_neg_in,
   // timers
   input wire logic t0_pwm_out,
   input wire logic t1_pwm_out,
   output logic timer0_pin,
   output logic timer1_pin,
   // uart
   input wire logic uart_tx,
   output logic uart_rx,
   // oscillator
   output logic osc_in_pin,
   output logic half_clock_out
);
   import pfm_pkg::*;

   logic half_clk_q;
   logic half_clk_d;
   logic dbg_on_p32;
   logic dbg_on_p33;
   logic [7:0] p1_claim;
   logic [7:0] p1_alt_out;
   logic [7:0] p1_alt_oe;
   logic [7:0] p3_claim;
   logic [7:0] p3_alt_out;
   logic [7:0] p3_alt_oe;

   // toggles each cycle to give half the internal clock
   assign half_clk_d = half_clk_q ^ HALF_CLK_DIV;
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !(cfg.rc_osc_sel && cfg.half_clk_en))
         half_clk_q <= HALF_CLK_RST;
      else
         half_clk_q <= half_clk_d;
   end

   assign dbg_on_p32 = cfg.onchip_debug && cfg.rc_osc_sel;
   assign dbg_on_p33 = cfg.onchip_debug && !cfg.rc_osc_sel;

   // port 1 alternate claims
   always_comb
   begin
      p1_claim = 8'h00;
      p1_alt_out = 8'h00;
      p1_alt_oe = 8'h00;
      if (cfg.spi_master)
      begin
         p1_claim[P1_MOSI] = 1'b1;
         p1_claim[P1_SCK] = 1'b1;
         p1_alt_out[P1_MOSI] = spi_mosi_out;
         p1_alt_out[P1_SCK] = spi_sck_out;
         p1_alt_oe[P1_MOSI] = 1'b1;
         p1_alt_oe[P1_SCK] = 1'b1;
         // miso held as input in master role, whatever the port mode says
         p1_claim[P1_MISO] = 1'b1;
      end
      else
      begin
         // mosi and sck held as inputs in slave role
         p1_claim[P1_MOSI] = 1'b1;
         p1_claim[P1_SCK] = 1'b1;
         p1_claim[P1_MISO] = 1'b1;
         p1_alt_out[P1_MISO] = spi_miso_out;
         p1_alt_oe[P1_MISO] = 1'b1;
      end
      // reset and debug clock are inputs only; the pin must never be driven
      if (cfg.reset_fuse || cfg.onchip_debug)
         p1_claim[P1_RST_DCL] = 1'b1;
   end

   // port 3 alternate claims
   always_comb
   begin
      p3_claim = 8'h00;
      p3_alt_out = 8'h00;
      p3_alt_oe = 8'h00;
      if (!cfg.rc_osc_sel)
      begin
         // oscillator owns both pins; the amplifier is outside this block
         p3_claim[P3_OSC_IN] = 1'b1;
         p3_claim[P3_OSC_OUT] = 1'b1;
      end
      else if (cfg.half_clk_en)
      begin
         p3_claim[P3_OSC_OUT] = 1'b1;
         p3_alt_out[P3_OSC_OUT] = half_clk_q;
         p3_alt_oe[P3_OSC_OUT] = 1'b1;
      end
      // debug data outranks port and clock output on its pin
      if (dbg_on_p32)
      begin
         p3_claim[P3_OSC_IN] = 1'b1;
         p3_alt_out[P3_OSC_IN] = debug_data_out;
         p3_alt_oe[P3_OSC_IN] = debug_data_oe;
      end
      if (dbg_on_p33)
      begin
         p3_claim[P3_OSC_OUT] = 1'b1;
         p3_alt_out[P3_OSC_OUT] = debug_data_out;
         p3_alt_oe[P3_OSC_OUT] = debug_data_oe;
      end
      if (cfg.t0_pwm_en)
      begin
         p3_claim[P3_T0] = 1'b1;
         p3_alt_out[P3_T0] = t0_pwm_out;
         p3_alt_oe[P3_T0] = 1'b1;
      end
      if (cfg.t1_pwm_en)
      begin
         p3_claim[P3_T1] = 1'b1;
         p3_alt_out[P3_T1] = t1_pwm_out;
         p3_alt_oe[P3_T1] = 1'b1;
      end
      if (cfg.uart_present)
      begin
         p3_claim[P3_TXD] = 1'b1;
         p3_alt_out[P3_TXD] = uart_tx;
         p3_alt_oe[P3_TXD] = 1'b1;
      end
   end

   // per-bit output select: alternate function or port register
   genvar i;
   generate
      for (i = 0; i < PORT_W; i++)
      begin : g_bit
         always_ff @(posedge sys_clk)
         begin
            if (sys_rst)
            begin
               port1_pin_out[i] <= 1'b0;
               port1_pin_oe[i] <= 1'b0;
               port3_pin_out[i] <= 1'b0;
               port3_pin_oe[i] <= 1'b0;
            end
            else
            begin
               port1_pin_out[i] <= p1_claim[i] ? p1_alt_out[i] : port1_reg[i];
               port1_pin_oe[i] <= p1_claim[i] ? p1_alt_oe[i] : port1_drv[i];
               port3_pin_out[i] <= p3_claim[i] ? p3_alt_out[i] : port3_reg[i];
               port3_pin_oe[i] <= p3_claim[i] ? p3_alt_oe[i] : port3_drv[i];
            end
         end
      end
   endgenerate

   // input taps are combinational: pins are already synchronous
   assign port1_read = port1_pin_in;
   assign port3_read = port3_pin_in;
   assign gp_irq_in = port1_pin_in;
   assign comparator_pos_in = port1_pin_in[P1_AIN_POS];
   assign comparator_neg_in = port1_pin_in[P1_AIN_NEG];
   assign spi_ss_n_in = port1_pin_in[P1_SS];
   assign spi_mosi_in = cfg.spi_master ? 1'b0 : port1_pin_in[P1_MOSI];
   assign spi_sck_in = cfg.spi_master ? 1'b0 : port1_pin_in[P1_SCK];
   assign spi_miso_in = cfg.spi_master ? port1_pin_in[P1_MISO] : 1'b0;
   // reset held inactive while fuse is off, so the pin stays a port bit
   assign ext_reset_n = cfg.reset_fuse ? port1_pin_in[P1_RST_DCL] : 1'b1;
   assign debug_clock_line = cfg.onchip_debug ? port1_pin_in[P1_RST_DCL] : 1'b0;
   assign debug_data_line = dbg_on_p32 ? port3_pin_in[P3_OSC_IN] :
                            dbg_on_p33 ? port3_pin_in[P3_OSC_OUT] : 1'b0;
   assign osc_in_pin = cfg.rc_osc_sel ? 1'b0 : port3_pin_in[P3_OSC_IN];
   assign timer0_pin = port3_pin_in[P3_T0];
   assign timer1_pin = port3_pin_in[P3_T1];
   assign uart_rx = cfg.uart_present ? port3_pin_in[P3_RXD] : 1'b1;
   assign half_clock_out = half_clk_q;
endmodule

// file: verification/pfm_pin_function_mux_properties.sv
`timescale 1ns/10ps
module pfm_checker
(
   input wire logic sys_clk, sys_rst,
   input wire pfm_pkg::pfm_cfg_s cfg,
   input wire logic [7:0] port1_pin_in, port1_pin_out, port1_pin_oe, gp_irq_in,
   input wire logic [7:0] port3_pin_in, port3_pin_out, port3_pin_oe, port3_drv,
   input wire logic spi_mosi_out, spi_miso_out, debug_data_oe, debug_data_line,
   input wire logic ext_reset_n, comparator_pos_in, uart_tx, half_clock_out
);
   import pfm_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   property p_mst;
      cfg.spi_master |=> port1_pin_oe[5] && port1_pin_out[5] == $past(spi_mosi_out);
   endproperty
   a_mst: assert property (p_mst) else $error("mosi");
   property p_slv;
      !cfg.spi_master |=> port1_pin_oe[6] && port1_pin_out[6] == $past(spi_miso_out);
   endproperty
   a_slv: assert property (p_slv) else $error("miso");
   property p_rel;
      cfg.rc_osc_sel && !cfg.onchip_debug |=> port3_pin_oe[2] == $past(port3_drv[2]);
   endproperty
   a_rel: assert property (p_rel) else $error("osc");
   property p_half;
      (cfg.rc_osc_sel && cfg.half_clk_en) [*2] |=> half_clock_out != $past(half_clock_out);
   endproperty
   a_half: assert property (p_half) else $error("half");
   property p_dbg;
      cfg.onchip_debug && !cfg.rc_osc_sel |-> debug_data_line == port3_pin_in[3]
         ##1 port3_pin_oe[3] == $past(debug_data_oe);
   endproperty
   a_dbg: assert property (p_dbg) else $error("dbg");
   property p_rst; ext_reset_n == (cfg.reset_fuse ? port1_pin_in[3] : 1'h1); endproperty
   a_rst: assert property (p_rst) else $error("rst");
   property p_irq; gp_irq_in == port1_pin_in && comparator_pos_in == port1_pin_in[0]; endproperty
   a_irq: assert property (p_irq) else $error("irq");
   property p_txd;
      cfg.uart_present |=> port3_pin_oe[1] && port3_pin_out[1] == $past(uart_tx);
   endproperty
   a_txd: assert property (p_txd) else $error("txd");
   c_spi: cover property (cfg.spi_master ##1 !cfg.spi_master);
   c_dbg: cover property (cfg.onchip_debug && cfg.rc_osc_sel);
   c_half: cover property (cfg.half_clk_en && half_clock_out);
endmodule

bind pfm_pin_function_mux pfm_checker u_pfm_checker (.*);

// file: verification/pfm_board.sv
`timescale 1ns/10ps
module pfm_board
(
   input wire logic [15:0] dev_out,
   input wire logic [15:0] dev_oe,
   input wire logic [15:0] lvl,
   output logic [15:0] pin
);
   // board keeps every line driven, debugger clock on p1 bit 3 included; device wins where enabled
   assign pin = (dev_oe & dev_out) | (~dev_oe & lvl);
endmodule

// file: verification/tb_pin_function_mux.sv
`timescale 1ns/10ps
module tb_pin_function_mux;
   import pfm_pkg::*;
   logic sys_clk = 1'h0;
   logic sys_rst = 1'h1;
   pfm_cfg_s cfg = '0;
   logic [7:0] u = 8'h00;
   logic [31:0] pr = 32'h0;
   logic [15:0] ext = 16'h0;
   wire logic [15:0] po, oe, pin;
   logic [7:0] v, gp_irq_in, port1_read, port3_read;
   logic h, spi_mosi_in, spi_sck_in, spi_miso_in, spi_ss_n_in, debug_data_line, debug_clock_line;
   logic ext_reset_n, comparator_pos_in, comparator_neg_in, timer0_pin, timer1_pin, uart_rx;
   logic osc_in_pin, half_clock_out;
   int mismatches = 0;
   int checks_done = 0;
   // unit outputs share one vector so each step changes them all in one go
   pfm_pin_function_mux u_pfm_pin_function_mux (.port1_reg(pr[7:0]), .port1_drv(pr[15:8]),
      .port3_reg(pr[23:16]), .port3_drv(pr[31:24]), .port1_pin_in(pin[7:0]),
      .port3_pin_in(pin[15:8]), .port1_pin_out(po[7:0]), .port3_pin_out(po[15:8]),
      .port1_pin_oe(oe[7:0]), .port3_pin_oe(oe[15:8]), .spi_mosi_out(u[0]), .spi_sck_out(u[1]),
      .spi_miso_out(u[2]), .debug_data_out(u[3]), .debug_data_oe(u[4]), .t0_pwm_out(u[5]),
      .t1_pwm_out(u[6]), .uart_tx(u[7]), .*);
   pfm_board u_pfm_board (.dev_out(po), .dev_oe(oe), .lvl(ext), .pin(pin));
   always #25 sys_clk = ~sys_clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic go(input logic [7:0] c, s, input logic [31:0] p, input logic [15:0] e);
      @(posedge sys_clk);
      cfg <= c;
      u <= s;
      pr <= p;
      ext <= e;
      @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'h0;
      go(8'h80, 8'h01, 32'h0, 16'h0040);
      chk({oe[7], oe[5], po[7], po[5], spi_miso_in, spi_ss_n_in, spi_mosi_in, 1'h0}, 8'hD8);
      go(8'h00, 8'h06, 32'hFFFF0000, 16'h04B0);
      chk({oe[6], po[6], oe[5], oe[7], spi_mosi_in, spi_sck_in, spi_ss_n_in, spi_miso_in}, 8'hCE);
      chk({oe[11:10], osc_in_pin}, 8'h01);
      go(8'h60, 8'h00, 32'hFFFF0000, 16'h0000);
      chk({oe[11:10], po[10]}, 8'h07);
      h = half_clock_out;
      @(negedge sys_clk);
      chk(half_clock_out, !h);
      go(8'h50, 8'h18, 32'h0, 16'h0008);
      chk({oe[10], po[10], debug_data_line, debug_clock_line, oe[3]}, 8'h1E);
      go(8'h10, 8'h00, 32'h0, 16'h0800);
      chk({oe[11], debug_data_line, oe[10], debug_clock_line}, 8'h04);
      go(8'h08, 8'h00, 32'h00000808, 16'h0000);
      chk({ext_reset_n, oe[3]}, 8'h00);
      go(8'h00, 8'h00, 32'h00000808, 16'h0000);
      chk({ext_reset_n, oe[3], po[3]}, 8'h07);
      for (int i = 0; i < 2; i++)
      begin
         v = 8'h25 ^ {8{i[0]}};
         go(8'h80, 8'h00, 32'h0, {8'h00, v});
         chk(gp_irq_in, v & 8'h5F);
         chk({comparator_pos_in, comparator_neg_in, port1_read[1:0]}, {v[0], v[1], v[1:0]});
      end
      go(8'h07, 8'hA0, 32'h00000404, 16'h0100);
      chk({oe[13:12], po[13:12], oe[9], po[9], uart_rx, timer0_pin}, 8'hDF);
      chk({oe[2], po[2], port1_read[2]}, 8'h07);
      chk({timer1_pin, port3_read[1:0]}, 8'h03);
      finish_test();
   end
   initial
   begin
      #20000;
      mismatches++;
      finish_test();
   end
endmodule
